// >>> rtl/lrsc_consts.svh
// constants for the ldo rail state control register bank
`ifndef LRSC_CONSTS_SVH
`define LRSC_CONSTS_SVH

// ==================================================================
// register addresses (7-bit spi register address)
`define LRSC_CORE_ADDR      7'h44
`define LRSC_AON_ADDR       7'h45
`define LRSC_LOWI_ADDR      7'h47

// ==================================================================
// reset values of the stored bits 5:0 (bits 7:6 are always zero)
`define LRSC_CORE_RST       6'h3c
`define LRSC_AON_RST        6'h07
`define LRSC_LOWI_RST       6'h24

// ==================================================================
// field layout of a rail control register
`define LRSC_STATE_MSB      2
`define LRSC_STATE_LSB      0
`define LRSC_EXIT_MSB       5
`define LRSC_EXIT_LSB       3
`define LRSC_RSVD_BITS      2'h0

// ==================================================================
// state codes
`define LRSC_CODE_OFF       3'h4
`define LRSC_CODE_LP        3'h5
`define LRSC_CODE_ACT0      3'h6
`define LRSC_CODE_ACT1      3'h7

// ==================================================================
// spi frame: bit 15 write flag, 14:8 address, 7:0 data, msb first
`define LRSC_FRAME_BITS     5'd16
`define LRSC_CMD_BITS       5'd8
`define LRSC_CNT_CMD_LAST   5'd7
`define LRSC_CNT_LAST       5'd15
`define LRSC_NO_RAIL        2'h3

`endif

// >>> rtl/lrsc_pkg.sv
// types shared by the ldo rail state control block
`default_nettype none
package lrsc_pkg;
   // regulator operating mode after decoding a state code
   typedef enum logic [1:0] {
      lrsc_mode_off = 2'b00,
      lrsc_mode_lp  = 2'b01,
      lrsc_mode_act = 2'b10
   } lrsc_mode_t;
endpackage : lrsc_pkg
`default_nettype wire

// >>> rtl/lrsc_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
`default_nettype none
module lrsc_sync #(
   parameter int          W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= RST_VAL;
         q_o    <= RST_VAL;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule : lrsc_sync
`default_nettype wire

// >>> rtl/lrsc_top.sv
// spi register bank and state control for three ldo rails
// Function
// - state field 2:0 selects rail: 4 off, 5 low power, 6 and 7 active.
// - standby exit copies exit field 5:3 into state field when it holds 4 to 7.
// - exit field codes 0 to 3 leave the state field unchanged on standby exit.
// - always-on rail register at 0x45, read/write, resets to 0x07.
// - low-current rail register at 0x47, read/write, resets to 0x24.
// - core rail register at 0x44, read/write, resets to 0x3c.
// - each rail is controlled only through its own register.
// - a rail in the off state has its output discharge enabled.
// - each rail reports its own over-current and under-voltage events.
// - bits 7:6 of each rail register carry no control function.
`include "lrsc_consts.svh"
`default_nettype none
module lrsc_top #(
   parameter int RAILS = 3
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             spi_sclk_i,
   input  wire logic             spi_cs_n_i,
   input  wire logic             spi_mosi_i,
   output logic                  spi_miso_o,
   output logic                  spi_miso_oe_o,
   input  wire logic             standby_exit_pin_i,
   input  wire logic [RAILS-1:0] oc_mon_i,
   input  wire logic [RAILS-1:0] uv_mon_i,
   output logic      [RAILS-1:0] rail_en_o,
   output logic      [RAILS-1:0] rail_lp_o,
   output logic      [RAILS-1:0] discharge_o,
   output logic      [RAILS-1:0] oc_event_o,
   output logic      [RAILS-1:0] uv_event_o
);
   // rail index 0 core_rail, 1 always_on_rail, 2 low_current_rail

   // ===============================================================
   // functions

   // register address to rail index, no-rail code when unmapped
   function automatic logic [1:0] addr_to_rail(input logic [6:0] addr);
      case (addr)
         `LRSC_CORE_ADDR: addr_to_rail = 2'h0;
         `LRSC_AON_ADDR:  addr_to_rail = 2'h1;
         `LRSC_LOWI_ADDR: addr_to_rail = 2'h2;
         default:         addr_to_rail = `LRSC_NO_RAIL;
      endcase
   endfunction : addr_to_rail

   // state code to mode; reserved codes fall back to off for safety
   function automatic lrsc_pkg::lrsc_mode_t decode_mode(input logic [2:0] code);
      case (code)
         `LRSC_CODE_LP:   decode_mode = lrsc_pkg::lrsc_mode_lp;
         `LRSC_CODE_ACT0: decode_mode = lrsc_pkg::lrsc_mode_act;
         `LRSC_CODE_ACT1: decode_mode = lrsc_pkg::lrsc_mode_act;
         default:         decode_mode = lrsc_pkg::lrsc_mode_off;
      endcase
   endfunction : decode_mode

   function automatic logic [5:0] rail_rst(input int r);
      case (r)
         0:       rail_rst = `LRSC_CORE_RST;
         1:       rail_rst = `LRSC_AON_RST;
         default: rail_rst = `LRSC_LOWI_RST;
      endcase
   endfunction : rail_rst

   // ===============================================================
   // pin synchronisers

   localparam int SW = 4 + 2 * RAILS;
   logic [SW-1:0] sync_s;
   logic          sclk_s;
   logic          cs_n_s;
   logic          mosi_s;
   logic          exit_s;
   logic [RAILS-1:0] oc_s;
   logic [RAILS-1:0] uv_s;

   // cs idles high so no frame is seen while the pin settles
   lrsc_sync #(
      .W       (SW),
      .RST_VAL ({{(SW-2){1'b0}}, 2'b10})
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({uv_mon_i, oc_mon_i, standby_exit_pin_i, spi_mosi_i, spi_cs_n_i, spi_sclk_i}),
      .q_o   (sync_s)
   );

   assign {uv_s, oc_s, exit_s, mosi_s, cs_n_s, sclk_s} = sync_s;

   // ===============================================================
   // edge detection on synchronised levels

   logic             sclk_d_q;
   logic             exit_d_q;
   logic [RAILS-1:0] oc_d_q;
   logic [RAILS-1:0] uv_d_q;
   logic             sclk_rise;
   logic             sclk_fall;
   logic             exit_edge;

   // previous values of the synchronised levels
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sclk_d_q <= 1'b0;
         exit_d_q <= 1'b0;
         oc_d_q   <= '0;
         uv_d_q   <= '0;
      end else begin
         sclk_d_q <= sclk_s;
         exit_d_q <= exit_s;
         oc_d_q   <= oc_s;
         uv_d_q   <= uv_s;
      end
   end

   assign sclk_rise = ~cs_n_s & sclk_s & ~sclk_d_q;
   assign sclk_fall = ~cs_n_s & ~sclk_s & sclk_d_q;
   assign exit_edge = exit_s & ~exit_d_q;

   // ===============================================================
   // spi shift engine (mode 0, 16-bit frame, msb first)

   logic [4:0]  bit_cnt_q;
   logic [14:0] shift_q;
   logic        rd_q;
   logic [7:0]  tx_q;
   logic        cmd_done;
   logic        frame_done;
   logic        wr_en;
   logic [6:0]  wr_addr;
   logic [7:0]  wr_data;
   logic [6:0]  rd_addr;
   logic [1:0]  wr_rail;
   logic [1:0]  rd_rail;

   assign cmd_done   = sclk_rise && (bit_cnt_q == `LRSC_CNT_CMD_LAST);
   assign frame_done = sclk_rise && (bit_cnt_q == `LRSC_CNT_LAST);
   assign wr_en      = frame_done & shift_q[14];
   assign wr_addr    = shift_q[13:7];
   assign wr_data    = {shift_q[6:0], mosi_s};
   assign rd_addr    = {shift_q[5:0], mosi_s};
   assign wr_rail    = addr_to_rail(wr_addr);
   assign rd_rail    = addr_to_rail(rd_addr);

   // bit counter saturates so trailing clocks of a long frame are ignored
   always_ff @(posedge clk_i) begin
      if (rst_i || cs_n_s) begin
         bit_cnt_q <= 5'd0;
         shift_q   <= '0;
      end else if (sclk_rise && bit_cnt_q != `LRSC_FRAME_BITS) begin
         bit_cnt_q <= bit_cnt_q + 5'd1;
         shift_q   <= {shift_q[13:0], mosi_s};
      end
   end

   logic [5:0] ctrl_q [RAILS];

   // read data is captured when the command byte completes
   always_ff @(posedge clk_i) begin
      if (rst_i || cs_n_s) begin
         rd_q <= 1'b0;
         tx_q <= 8'h00;
      end else if (cmd_done) begin
         rd_q <= ~shift_q[6];
         tx_q <= (rd_rail == `LRSC_NO_RAIL) ? 8'h00 : {`LRSC_RSVD_BITS, ctrl_q[rd_rail]};
      end else if (sclk_fall && rd_q && bit_cnt_q >= `LRSC_CMD_BITS
                   && bit_cnt_q <= `LRSC_CNT_LAST) begin
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   // miso changes on the falling sclk so the host samples on the rising one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         spi_miso_o    <= 1'b0;
         spi_miso_oe_o <= 1'b0;
      end else begin
         spi_miso_oe_o <= ~cs_n_s;
         if (cs_n_s) begin
            spi_miso_o <= 1'b0;
         end else if (sclk_fall && rd_q && bit_cnt_q >= `LRSC_CMD_BITS
                      && bit_cnt_q <= `LRSC_CNT_LAST) begin
            spi_miso_o <= tx_q[7];
         end
      end
   end

   // ===============================================================
   // rail registers and rail outputs

   logic [RAILS-1:0] wr_hit;
   for (genvar r = 0; r < RAILS; r++) begin : g_rail
      logic [5:0] ctrl_d;
      lrsc_pkg::lrsc_mode_t mode;

      assign wr_hit[r] = wr_en && (wr_rail == 2'(r));

      // a write lands first; a coinciding exit edge then copies the new field
      always_comb begin
         ctrl_d = ctrl_q[r];
         if (wr_hit[r]) begin
            ctrl_d = wr_data[5:0];
         end
         if (exit_edge && ctrl_d[`LRSC_EXIT_MSB]) begin
            ctrl_d[`LRSC_STATE_MSB:`LRSC_STATE_LSB] = ctrl_d[`LRSC_EXIT_MSB:`LRSC_EXIT_LSB];
         end
         // codes 0-3 keep state (no branch taken)
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            ctrl_q[r] <= rail_rst(r);
         end else begin
            ctrl_q[r] <= ctrl_d;
         end
      end

      assign mode = decode_mode(ctrl_q[r][`LRSC_STATE_MSB:`LRSC_STATE_LSB]);

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            rail_en_o[r]   <= 1'b0;
            rail_lp_o[r]   <= 1'b0;
            discharge_o[r] <= 1'b1;
         end else begin
            rail_en_o[r]   <= (mode != lrsc_pkg::lrsc_mode_off);
            rail_lp_o[r]   <= (mode == lrsc_pkg::lrsc_mode_lp);
            discharge_o[r] <= (mode == lrsc_pkg::lrsc_mode_off);
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            oc_event_o[r] <= 1'b0;
            uv_event_o[r] <= 1'b0;
         end else begin
            oc_event_o[r] <= oc_s[r] & ~oc_d_q[r];
            uv_event_o[r] <= uv_s[r] & ~uv_d_q[r];
         end
      end

      // ============================================================
      // per-rail assertions

      property p_active_decode;
         @(posedge clk_i) disable iff (rst_i)
         (ctrl_q[r][2:1] == 2'b11) |=> (rail_en_o[r] && !rail_lp_o[r]);
      endproperty
      a_active_decode: assert property (p_active_decode)
         else $error("active code did not enable rail at full power");
      property p_off_discharge;
         @(posedge clk_i) disable iff (rst_i)
         (ctrl_q[r][2:0] == 3'h4) |=> (discharge_o[r] && !rail_en_o[r]);
      endproperty
      a_off_discharge: assert property (p_off_discharge)
         else $error("off rail without discharge");
      property p_exit_copy;
         @(posedge clk_i) disable iff (rst_i)
         (exit_edge && !wr_en && ctrl_q[r][5]) |=> (ctrl_q[r][2:0] == $past(ctrl_q[r][5:3]));
      endproperty
      a_exit_copy: assert property (p_exit_copy)
         else $error("exit field not copied");
      property p_exit_nocopy;
         @(posedge clk_i) disable iff (rst_i)
         (exit_edge && !wr_en && !ctrl_q[r][5]) |=> $stable(ctrl_q[r][2:0]);
      endproperty
      a_exit_nocopy: assert property (p_exit_nocopy)
         else $error("state changed on no-copy exit code");
      property p_independent;
         @(posedge clk_i) disable iff (rst_i)
         (!wr_hit[r] && !exit_edge) |=> $stable(ctrl_q[r]);
      endproperty
      a_independent: assert property (p_independent)
         else $error("rail register changed by another access");
      property p_oc_event;
         @(posedge clk_i) disable iff (rst_i)
         $rose(oc_s[r]) |=> oc_event_o[r] ##1 !oc_event_o[r];
      endproperty
      a_oc_event: assert property (p_oc_event)
         else $error("over-current event not a single pulse");
   end

   // ===============================================================
   // bank-wide assertions and covers

   property p_rst_core;
      @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> (ctrl_q[0] == 6'h3c);
   endproperty
   a_rst_core: assert property (p_rst_core)
      else $error("core rail register reset value wrong");
   property p_rst_aon;
      @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> (ctrl_q[1] == 6'h07 && rail_en_o[1] == 1'b0);
   endproperty
   a_rst_aon: assert property (p_rst_aon)
      else $error("always-on rail register reset value wrong");
   property p_rst_lowi;
      @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> ##1 (ctrl_q[2] == 6'h24 || $past(wr_hit[2]) || $past(exit_edge));
   endproperty
   a_rst_lowi: assert property (p_rst_lowi)
      else $error("low-current rail register reset value wrong");
   property p_rsvd_read;
      @(posedge clk_i) disable iff (rst_i)
      cmd_done |=> (tx_q[7:6] == 2'b00);
   endproperty
   a_rsvd_read: assert property (p_rsvd_read)
      else $error("reserved bits read non-zero");
   property p_one_copy;
      @(posedge clk_i) disable iff (rst_i)
      (exit_s && exit_d_q && !wr_hit[0]) |=> $stable(ctrl_q[0]);
   endproperty
   a_one_copy: assert property (p_one_copy)
      else $error("more than one copy for one exit edge");
   c_write: cover property (@(posedge clk_i) disable iff (rst_i) wr_en && wr_rail != 2'h3);
   c_read: cover property (@(posedge clk_i) disable iff (rst_i) cmd_done && !shift_q[6]);
   c_exit: cover property (@(posedge clk_i) disable iff (rst_i) exit_edge && ctrl_q[0][5]);
   c_event: cover property (@(posedge clk_i) disable iff (rst_i) |uv_event_o);

endmodule : lrsc_top
`default_nettype wire

// >>> tb/lrsc_host.sv
// behavioural spi host that programs the rail control registers
`default_nettype none
module lrsc_host (
   input  wire logic clk_i,
   input  wire logic miso_i,
   output var  logic sclk_o,
   output var  logic cs_n_o,
   output var  logic mosi_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // idle lines
   // sclk parks low between frames, select stays high
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end

   // ==========================================================
   // frame engine
   // no reserved codes: callers hand over state codes 4 to 7 only
   // miso is taken just before each of the last 8 falls, after the synchronisers settle
   task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      logic [15:0] frame;
      frame = {wr, a, d};
      q = 8'h00;
      @(negedge clk_i);
      cs_n_o = 1'b0;
      repeat (4) @(negedge clk_i);
      for (int i = 15; i >= 0; i--) begin
         mosi_o = frame[i];
         repeat (4) @(negedge clk_i);
         sclk_o = 1'b1;
         repeat (4) @(negedge clk_i);
         if (i < 8) q[i] = miso_i;
         sclk_o = 1'b0;
      end
      repeat (4) @(negedge clk_i);
      cs_n_o = 1'b1;
      mosi_o = ~frame[0]; // released line must not keep the last bit
      repeat (4) @(negedge clk_i);
   endtask : xfer
endmodule : lrsc_host
`default_nettype wire

// >>> tb/lrsc_top_bench.sv
// self-checking bench for the rail control register bank
`default_nettype none
`define CHK(got, exp) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) begin \
         bad_count++; \
         $display("unexpected at %0t: got %h want %h", $time, got, exp); \
      end \
   end

module lrsc_top_bench;
   timeunit 1ns;
   timeprecision 100ps;

   logic       clk_i, rst_i, sclk, cs_n, mosi, miso, miso_oe, exit_pin;
   logic [2:0] oc_mon, uv_mon, rail_en, rail_lp, dis, oc_ev, uv_ev;
   int         bad_count    = 0;
   int         total_checks = 0;

   // ==========================================================
   // clock, design and host
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   lrsc_top i_dut (
      .clk_i              (clk_i),
      .rst_i              (rst_i),
      .spi_sclk_i         (sclk),
      .spi_cs_n_i         (cs_n),
      .spi_mosi_i         (mosi),
      .spi_miso_o         (miso),
      .spi_miso_oe_o      (miso_oe),
      .standby_exit_pin_i (exit_pin),
      .oc_mon_i           (oc_mon),
      .uv_mon_i           (uv_mon),
      .rail_en_o          (rail_en),
      .rail_lp_o          (rail_lp),
      .discharge_o        (dis),
      .oc_event_o         (oc_ev),
      .uv_event_o         (uv_ev)
   );

   lrsc_host i_host (
      .clk_i  (clk_i),
      .miso_i (miso),
      .sclk_o (sclk),
      .cs_n_o (cs_n),
      .mosi_o (mosi)
   );

   // ==========================================================
   // access and check tasks
   task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] junk;
      i_host.xfer(1'b1, a, d, junk);
      // deselected: output enable dropped and data line parked low
      `CHK({miso_oe, miso}, 2'b00)
   endtask : wr_reg

   task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] got;
      // output enable must stand while the frame is in flight
      fork
         i_host.xfer(1'b0, a, 8'h00, got);
         begin
            repeat (20) @(negedge clk_i);
            `CHK(miso_oe, 1'b1)
         end
      join
      `CHK(got, exp)
      `CHK({miso_oe, miso}, 2'b00)
   endtask : rd_chk

   // expected {en, lp, discharge} for a state code of 4 to 7
   task automatic rail_chk(input int r, input logic [2:0] c);
      logic [2:0] exp;
      exp = (c == 3'h4) ? 3'b001 : (c == 3'h5) ? 3'b110 : 3'b100;
      `CHK({rail_en[r], rail_lp[r], dis[r]}, exp)
   endtask : rail_chk

   // one monitor trip must give exactly one pulse, on its own rail and kind
   task automatic mon_chk(input int r, input logic uv);
      logic [5:0] seen;
      int         n;
      seen = 6'h00;
      n = 0;
      if (uv) uv_mon[r] = 1'b1;
      else oc_mon[r] = 1'b1;
      repeat (12) begin
         @(negedge clk_i);
         seen = seen | {oc_ev, uv_ev};
         n = n + $countones({oc_ev, uv_ev});
      end
      `CHK(seen, uv ? 6'h01 << r : 6'h08 << r)
      `CHK(n, 1)
      oc_mon = 3'h0;
      uv_mon = 3'h0;
      repeat (6) @(negedge clk_i);
   endtask : mon_chk

   task automatic pin_edge;
      exit_pin = 1'b0;
      repeat (4) @(negedge clk_i);
      exit_pin = 1'b1;
      repeat (10) @(negedge clk_i);
   endtask : pin_edge

   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop

   // ==========================================================
   // watchdog: whole sequence needs well under 8000 cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      report_and_stop();
   end

   // ==========================================================
   // test sequence
   initial begin
      rst_i = 1'b1;
      exit_pin = 1'b0;
      oc_mon = 3'h0;
      uv_mon = 3'h0;
      repeat (20) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge clk_i);
      rd_chk(7'h44, 8'h3c);
      rd_chk(7'h45, 8'h07);
      rd_chk(7'h47, 8'h24);
      rail_chk(0, 3'h4);
      rail_chk(1, 3'h7);
      rail_chk(2, 3'h4);
      $display("test reset values done");
      wr_reg(7'h44, 8'hee);
      rd_chk(7'h44, 8'h2e);
      rail_chk(0, 3'h6);
      wr_reg(7'h46, 8'h3d);
      rd_chk(7'h46, 8'h00);
      rd_chk(7'h45, 8'h07);
      rd_chk(7'h47, 8'h24);
      $display("test reserved bits and unmapped done");
      // every state code, back-to-back frames, core rail must not move
      for (int c = 4; c < 8; c++) begin
         wr_reg(7'h47, {5'h04, c[2:0]});
         rd_chk(7'h47, {5'h04, c[2:0]});
         rail_chk(2, c[2:0]);
         rail_chk(0, 3'h6);
      end
      $display("test state codes done");
      // exit fields set before the pin is used
      wr_reg(7'h44, 8'h2c);
      wr_reg(7'h45, 8'h17);
      wr_reg(7'h47, 8'h3c);
      pin_edge();
      rd_chk(7'h44, 8'h2d);
      rd_chk(7'h45, 8'h17);
      rd_chk(7'h47, 8'h3f);
      rail_chk(0, 3'h5);
      rail_chk(2, 3'h7);
      // pin held high: a rewrite must survive
      wr_reg(7'h44, 8'h2c);
      wr_reg(7'h45, 8'h27);
      repeat (10) @(negedge clk_i);
      rd_chk(7'h44, 8'h2c);
      pin_edge();
      exit_pin = 1'b0;
      rd_chk(7'h44, 8'h2d);
      rd_chk(7'h45, 8'h24);
      rail_chk(1, 3'h4);
      $display("test standby exit done");
      for (int r = 0; r < 3; r++) begin
         mon_chk(r, 1'b0);
         mon_chk(r, 1'b1);
      end
      $display("test monitors done");
      report_and_stop();
   end
endmodule : lrsc_top_bench
`default_nettype wire
